// ===== hw/eti_pkg.sv
// constants and types for the event-to-task channel register bank
// How it works
// - A write to group n's disable trigger at 0x004 plus n times 0x8 disables group n.
// - Writing 1 to a bit of the set alias enables that channel; a 0 bit changes nothing.
// - Writing 1 to a bit of the clear alias disables that channel; a 0 bit changes nothing.
// - Reading the set or clear alias returns the current channel enable bits.
// - Channels 0 to 19 each own an event end-point word at 0x510 plus n times 0x8.
// - Channels 0 to 19 each own a read-write task end-point word at 0x514 plus n times 0x8.
// - Six group masks at 0x800 plus n times 0x4 hold one inclusion bit per channel, reset 0.
// - A write to group n's enable trigger at 0x000 plus n times 0x8 enables group n.
// - Channels 20 to 31 are fixed by hardware and own no end-point words.
package eti_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 32;
	localparam int NUM_CFG_CH = 20;
	localparam int NUM_GRP = 6;
	localparam int NUM_EP_WORDS = 40;
	localparam int EP_IDX_W = 6;
	localparam int GRP_IDX_W = 3;

	// group trigger words: enable at even word, disable at odd word
	localparam logic [ADDR_W-1:0] OFF_GRP_EN = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_GRP_DIS = 12'h004;
	localparam logic [ADDR_W-1:0] GRP_TRIG_STRIDE = 12'h008;
	localparam logic [ADDR_W-1:0] GRP_TRIG_END = 12'h030;

	// channel enable and its aliases
	localparam logic [ADDR_W-1:0] OFF_CHAN_ENABLE = 12'h500;
	localparam logic [ADDR_W-1:0] OFF_CHAN_ENABLE_SET = 12'h504;
	localparam logic [ADDR_W-1:0] OFF_CHAN_ENABLE_CLEAR = 12'h508;

	// end-point words: event then task, pairs per channel
	localparam logic [ADDR_W-1:0] OFF_EVENT_ENDPOINT = 12'h510;
	localparam logic [ADDR_W-1:0] OFF_TASK_ENDPOINT = 12'h514;
	localparam logic [ADDR_W-1:0] EP_STRIDE = 12'h008;
	localparam logic [ADDR_W-1:0] EP_END = 12'h5B0;

	// group masks
	localparam logic [ADDR_W-1:0] OFF_GROUP_MASK = 12'h800;
	localparam logic [ADDR_W-1:0] GROUP_MASK_STRIDE = 12'h004;
	localparam logic [ADDR_W-1:0] GROUP_MASK_END = 12'h818;

	// reset values
	localparam logic [DATA_W-1:0] CHAN_ENABLE_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] GROUP_MASK_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] ENDPOINT_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;

	typedef logic [NUM_GRP-1:0][DATA_W-1:0] eti_masks_t;
endpackage

// ===== hw/eti_ep_mem.sv
// end-point word storage with a registered read port
module eti_ep_mem (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic we_i,
	input wire logic [eti_pkg::EP_IDX_W-1:0] waddr_i,
	input wire logic [eti_pkg::DATA_W-1:0] wdata_i,
	input wire logic re_i,
	input wire logic [eti_pkg::EP_IDX_W-1:0] raddr_i,
	input wire logic alt_sel_i,
	input wire logic [eti_pkg::DATA_W-1:0] alt_data_i,
	output logic [eti_pkg::DATA_W-1:0] rdata_o
);
	import eti_pkg::*;

	logic [DATA_W-1:0] mem_reg [NUM_EP_WORDS];

	// storage; all words clear so task pointers start at zero
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < NUM_EP_WORDS; i++) begin
				mem_reg[i] <= ENDPOINT_RESET;
			end
		end else if (we_i && (int'(waddr_i) < NUM_EP_WORDS)) begin
			mem_reg[waddr_i] <= wdata_i;
		end
	end

	// shared read register; other registers ride through alt so the
	// bus sees one flop and one cycle of latency for every word
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_o <= UNMAPPED_READ;
		end else if (re_i) begin
			rdata_o <= alt_sel_i ? alt_data_i : mem_reg[raddr_i];
		end else begin
			rdata_o <= UNMAPPED_READ;
		end
	end
endmodule

// ===== hw/eti_grp_ctrl.sv
// group enable and disable trigger decode into set and clear vectors
module eti_grp_ctrl (
	input wire logic we_i,
	input wire logic [eti_pkg::ADDR_W-1:0] addr_i,
	input wire logic [eti_pkg::NUM_GRP-1:0] grp_en_task_i,
	input wire logic [eti_pkg::NUM_GRP-1:0] grp_dis_task_i,
	input wire eti_pkg::eti_masks_t masks_i,
	output logic [eti_pkg::DATA_W-1:0] set_vec_o,
	output logic [eti_pkg::DATA_W-1:0] clr_vec_o
);
	import eti_pkg::*;

	logic [NUM_GRP-1:0] en_hit;
	logic [NUM_GRP-1:0] dis_hit;

	// bus trigger words merged with hardware task pulses; data is ignored
	always_comb begin
		for (int g = 0; g < NUM_GRP; g++) begin
			en_hit[g] = grp_en_task_i[g] ||
				(we_i && addr_i == OFF_GRP_EN + ADDR_W'(g) * GRP_TRIG_STRIDE);
			dis_hit[g] = grp_dis_task_i[g] ||
				(we_i && addr_i == OFF_GRP_DIS + ADDR_W'(g) * GRP_TRIG_STRIDE);
		end
	end

	// only member channels move; several groups may fire together
	always_comb begin
		set_vec_o = '0;
		clr_vec_o = '0;
		for (int g = 0; g < NUM_GRP; g++) begin
			if (en_hit[g]) begin
				set_vec_o = set_vec_o | masks_i[g];
			end
			if (dis_hit[g]) begin
				clr_vec_o = clr_vec_o | masks_i[g];
			end
		end
	end
endmodule

// ===== hw/eti_regs.sv
// register bank of the event-to-task channel interconnect
//
// Chosen here: the plain strobed port.
module eti_regs (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [eti_pkg::ADDR_W-1:0] addr_i,
	input wire logic [eti_pkg::DATA_W-1:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	input wire logic [eti_pkg::NUM_GRP-1:0] grp_en_task_i,
	input wire logic [eti_pkg::NUM_GRP-1:0] grp_dis_task_i,
	output logic [eti_pkg::DATA_W-1:0] rdata_o,
	output logic [eti_pkg::NUM_CH-1:0] channel_enable_o
);
	import eti_pkg::*;

	logic [NUM_CH-1:0] chan_en_reg;
	logic [NUM_CH-1:0] chan_en_next;
	eti_masks_t masks_reg;
	logic [DATA_W-1:0] set_vec;
	logic [DATA_W-1:0] clr_vec;
	logic ep_we;
	logic [EP_IDX_W-1:0] ep_idx;
	logic alt_sel;
	logic [DATA_W-1:0] alt_data;

	// true for an address inside the end-point words of channels 0..19
	function automatic logic is_endpoint(input logic [ADDR_W-1:0] a);
		return (a >= OFF_EVENT_ENDPOINT) && (a < EP_END) && (a[1:0] == 2'b00);
	endfunction

	// word index into end-point storage: even is event, odd is task
	function automatic logic [EP_IDX_W-1:0] endpoint_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - OFF_EVENT_ENDPOINT;
		return d[EP_IDX_W+1:2];
	endfunction

	// true for a group mask word of groups 0..5
	function automatic logic is_group_mask(input logic [ADDR_W-1:0] a);
		return (a >= OFF_GROUP_MASK) && (a < GROUP_MASK_END) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [GRP_IDX_W-1:0] group_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - OFF_GROUP_MASK;
		return d[GRP_IDX_W+1:2];
	endfunction

	// group triggers from the bus and from routed hardware tasks
	eti_grp_ctrl u_grp (
		.we_i(we_i),
		.addr_i(addr_i),
		.grp_en_task_i(grp_en_task_i),
		.grp_dis_task_i(grp_dis_task_i),
		.masks_i(masks_reg),
		.set_vec_o(set_vec),
		.clr_vec_o(clr_vec)
	);

	// next enable: plain write first, then sets, then clears last so a
	// disable always beats an enable landing in the same cycle
	always_comb begin
		chan_en_next = chan_en_reg;
		if (we_i && addr_i == OFF_CHAN_ENABLE) begin
			chan_en_next = wdata_i;
		end
		if (we_i && addr_i == OFF_CHAN_ENABLE_SET) begin
			chan_en_next = chan_en_next | wdata_i;
		end
		chan_en_next = chan_en_next | set_vec;
		if (we_i && addr_i == OFF_CHAN_ENABLE_CLEAR) begin
			chan_en_next = chan_en_next & ~wdata_i;
		end
		chan_en_next = chan_en_next & ~clr_vec;
	end

	// channel enable state, also driven straight out to the router
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			chan_en_reg <= CHAN_ENABLE_RESET;
		end else begin
			chan_en_reg <= chan_en_next;
		end
	end

	assign channel_enable_o = chan_en_reg;

	// group masks; a write replaces the whole word
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			for (int g = 0; g < NUM_GRP; g++) begin
				masks_reg[g] <= GROUP_MASK_RESET;
			end
		end else if (we_i && is_group_mask(addr_i)) begin
			masks_reg[group_index(addr_i)] <= wdata_i;
		end
	end

	// end-point decode; nothing exists past channel 19 since the fixed
	// channels are wired in the router and cannot be rewritten
	always_comb begin
		ep_we = we_i && is_endpoint(addr_i);
		ep_idx = endpoint_index(addr_i);
	end

	// read mux for everything not held in end-point storage
	always_comb begin
		alt_sel = !is_endpoint(addr_i);
		alt_data = UNMAPPED_READ;
		if (addr_i == OFF_CHAN_ENABLE) begin
			alt_data = chan_en_reg;
		end else if (addr_i == OFF_CHAN_ENABLE_SET || addr_i == OFF_CHAN_ENABLE_CLEAR) begin
			alt_data = chan_en_reg;
		end else if (is_group_mask(addr_i)) begin
			alt_data = masks_reg[group_index(addr_i)];
		end
	end

	// end-point words; the pointer is stored as written, no task check
	eti_ep_mem u_mem (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.we_i(ep_we),
		.waddr_i(ep_idx),
		.wdata_i(wdata_i),
		.re_i(re_i),
		.raddr_i(ep_idx),
		.alt_sel_i(alt_sel),
		.alt_data_i(alt_data),
		.rdata_o(rdata_o)
	);

	// assertion helpers
	logic hw_idle;
	logic [ADDR_W-1:0] grp0_en_addr;
	logic [ADDR_W-1:0] grp5_dis_addr;
	logic [ADDR_W-1:0] task0_addr;
	logic [ADDR_W-1:0] fixed_ep_addr;
	logic [ADDR_W-1:0] event0_addr;
	logic [ADDR_W-1:0] task19_addr;
	logic [ADDR_W-1:0] grp5_mask_addr;
	assign hw_idle = (grp_en_task_i == '0) && (grp_dis_task_i == '0);
	assign grp0_en_addr = OFF_GRP_EN;
	assign grp5_dis_addr = OFF_GRP_DIS + ADDR_W'(NUM_GRP - 1) * GRP_TRIG_STRIDE;
	assign task0_addr = OFF_TASK_ENDPOINT;
	assign fixed_ep_addr = EP_END;
	assign event0_addr = OFF_EVENT_ENDPOINT;
	assign task19_addr = OFF_TASK_ENDPOINT + ADDR_W'(NUM_CFG_CH - 1) * EP_STRIDE;
	assign grp5_mask_addr = OFF_GROUP_MASK + ADDR_W'(NUM_GRP - 1) * GROUP_MASK_STRIDE;

	sequence s_task0_write;
		we_i && addr_i == task0_addr;
	endsequence

	sequence s_task0_read;
		re_i && addr_i == task0_addr;
	endsequence

	sequence s_alias_read;
		re_i && (addr_i == OFF_CHAN_ENABLE_SET || addr_i == OFF_CHAN_ENABLE_CLEAR);
	endsequence

	sequence s_event0_write;
		we_i && addr_i == event0_addr;
	endsequence

	sequence s_event0_read;
		re_i && addr_i == event0_addr;
	endsequence

	sequence s_task19_write;
		we_i && addr_i == task19_addr;
	endsequence

	sequence s_task19_read;
		re_i && addr_i == task19_addr;
	endsequence

	sequence s_mask0_write;
		we_i && addr_i == OFF_GROUP_MASK;
	endsequence

	sequence s_mask0_read;
		re_i && addr_i == OFF_GROUP_MASK;
	endsequence

	sequence s_enable_read;
		re_i && addr_i == OFF_CHAN_ENABLE;
	endsequence

	// last group disable clears every member channel
	a_grp_disable_clears: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i == grp5_dis_addr
		|=> (channel_enable_o & $past(masks_reg[NUM_GRP-1])) == '0)
		else $error("group disable left a member channel enabled");

	// group 0 enable sets every member channel when nothing clears
	a_grp_enable_sets: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i == grp0_en_addr && hw_idle
		|=> (channel_enable_o & $past(masks_reg[0])) == $past(masks_reg[0]))
		else $error("group enable missed a member channel");

	// plain write replaces the enable word
	a_enable_write: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i == OFF_CHAN_ENABLE && hw_idle
		|=> channel_enable_o == $past(wdata_i))
		else $error("channel enable write not stored");

	// set alias only adds ones
	a_set_alias: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i == OFF_CHAN_ENABLE_SET && hw_idle
		|=> channel_enable_o == ($past(channel_enable_o) | $past(wdata_i)))
		else $error("set alias result wrong");

	// clear alias only removes ones
	a_clear_alias: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i == OFF_CHAN_ENABLE_CLEAR && hw_idle
		|=> channel_enable_o == ($past(channel_enable_o) & ~$past(wdata_i)))
		else $error("clear alias result wrong");

	// alias reads return the enable state in the next cycle
	a_alias_readback: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		s_alias_read |=> rdata_o == $past(channel_enable_o))
		else $error("alias read did not return channel enable");

	// task pointer written then read back unchanged
	a_task_readback: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		s_task0_write ##1 s_task0_read |=> rdata_o == $past(wdata_i, 2))
		else $error("task end-point read back wrong");

	// mask write lands in the addressed group
	a_mask_write: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i == OFF_GROUP_MASK
		|=> masks_reg[0] == $past(wdata_i))
		else $error("group mask write not stored");

	// disable beats enable on the same group in one cycle
	a_disable_wins: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		grp_en_task_i[0] && grp_dis_task_i[0]
		|=> (channel_enable_o & $past(masks_reg[0])) == '0)
		else $error("group enable beat a simultaneous disable");

	// no end-point word for the first fixed channel
	a_fixed_unmapped: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		re_i && addr_i == fixed_ep_addr |=> rdata_o == UNMAPPED_READ)
		else $error("fixed channel end-point is readable");

	// group tasks leave channels outside the masks alone
	a_outside_kept: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		resetn_i && !we_i ##1 !we_i
		|-> (channel_enable_o & ~$past(set_vec) & ~$past(clr_vec))
			== ($past(channel_enable_o) & ~$past(set_vec) & ~$past(clr_vec)))
		else $error("group task moved a non-member channel");

	// read data stand one cycle only
	a_read_one_cycle: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		!re_i |=> rdata_o == UNMAPPED_READ)
		else $error("read data held past its cycle");

	// enable word reads back what it holds
	a_enable_readback: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		s_enable_read |=> rdata_o == $past(channel_enable_o))
		else $error("channel enable read back wrong");

	// reset leaves every channel disabled, mid-run too
	a_enable_reset: assert property (
		@(posedge clk_i)
		!resetn_i |=> channel_enable_o == CHAN_ENABLE_RESET)
		else $error("channel enable not cleared by reset");

	// reset empties every group
	a_mask_reset: assert property (
		@(posedge clk_i)
		!resetn_i |=> masks_reg == '0)
		else $error("group mask not cleared by reset");

	// event pointer written then read back unchanged
	a_event_readback: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		s_event0_write ##1 s_event0_read |=> rdata_o == $past(wdata_i, 2))
		else $error("event end-point read back wrong");

	// last configurable channel owns its own task word
	a_task_last_readback: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		s_task19_write ##1 s_task19_read |=> rdata_o == $past(wdata_i, 2))
		else $error("last task end-point read back wrong");

	// nothing past channel 19 reaches end-point storage
	a_fixed_no_store: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i >= fixed_ep_addr && addr_i < OFF_GROUP_MASK |-> !ep_we)
		else $error("write past channel 19 reached end-point storage");

	// mask word reads back what was written
	a_mask_readback: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		s_mask0_write ##1 s_mask0_read |=> rdata_o == $past(wdata_i, 2))
		else $error("group mask read back wrong");

	// last group mask is a word of its own
	a_mask_last_group: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i == grp5_mask_addr |=> masks_reg[NUM_GRP-1] == $past(wdata_i))
		else $error("last group mask write not stored");

	// a mask write leaves other groups alone
	a_mask_others_kept: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && is_group_mask(addr_i) && addr_i != OFF_GROUP_MASK
		|=> masks_reg[0] == $past(masks_reg[0]))
		else $error("mask write hit the wrong group");

	// hardware group enable sets every member channel
	a_hw_enable_sets: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		grp_en_task_i[2] && grp_dis_task_i == '0 && !we_i
		|=> (channel_enable_o & $past(masks_reg[2])) == $past(masks_reg[2]))
		else $error("hardware group enable missed a member channel");

	// hardware group disable clears every member channel
	a_hw_disable_clears: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		grp_dis_task_i[1] |=> (channel_enable_o & $past(masks_reg[1])) == '0)
		else $error("hardware group disable left a member channel enabled");

	// bus group enable leaves non-members alone
	a_grp_en_outsiders: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i == grp0_en_addr && hw_idle
		|=> (channel_enable_o & ~$past(masks_reg[0]))
			== ($past(channel_enable_o) & ~$past(masks_reg[0])))
		else $error("group enable moved a non-member channel");

	// bus group disable leaves non-members alone
	a_grp_dis_outsiders: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		we_i && addr_i == grp5_dis_addr && hw_idle
		|=> (channel_enable_o & ~$past(masks_reg[NUM_GRP-1]))
			== ($past(channel_enable_o) & ~$past(masks_reg[NUM_GRP-1])))
		else $error("group disable moved a non-member channel");
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the event-to-task channel register bank
module tb_top;
timeunit 1ns;
timeprecision 1ps;
import eti_pkg::*;

typedef struct {
	logic [ADDR_W-1:0] wa;
	logic [DATA_W-1:0] wd;
	logic [ADDR_W-1:0] ra;
	logic [DATA_W-1:0] ex;
} eti_row_t;

logic clk_i;
logic resetn_i;
logic [ADDR_W-1:0] addr_i;
logic [DATA_W-1:0] wdata_i;
logic we_i;
logic re_i;
logic [NUM_GRP-1:0] grp_en_task_i;
logic [NUM_GRP-1:0] grp_dis_task_i;
logic [DATA_W-1:0] rdata_o;
logic [NUM_CH-1:0] channel_enable_o;
int err_total;
int checked;
int cycles;
logic [DATA_W-1:0] v;
logic [DATA_W-1:0] m;
eti_row_t rows [11];

eti_regs uut (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.we_i(we_i),
	.re_i(re_i),
	.grp_en_task_i(grp_en_task_i),
	.grp_dis_task_i(grp_dis_task_i),
	.rdata_o(rdata_o),
	.channel_enable_o(channel_enable_o)
);

// free-running 200 MHz clock
initial begin
	clk_i = 1'b0;
	forever #2.5 clk_i = ~clk_i;
end

// hang guard, far above the roughly 105 cycles the tests need
always @(posedge clk_i) begin
	cycles <= cycles + 1;
	if (cycles == 2000) begin
		err_total++;
		print_verdict();
	end
end

task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
	checked++;
	if (seen !== exp) begin
		err_total++;
		$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
	end
endtask

// strobe is left high; the next rd or idle lowers it on the next edge
task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
	@(posedge clk_i);
	we_i <= 1'b1;
	re_i <= 1'b0;
	addr_i <= a;
	wdata_i <= d;
endtask

task automatic idle();
	@(posedge clk_i);
	we_i <= 1'b0;
	re_i <= 1'b0;
	grp_en_task_i <= 6'h00;
	grp_dis_task_i <= 6'h00;
	#1;
endtask

// read data stand only in the cycle after the strobe
task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
	@(posedge clk_i);
	re_i <= 1'b1;
	we_i <= 1'b0;
	addr_i <= a;
	idle();
	d = rdata_o;
endtask

task automatic print_verdict();
	$display("comparisons %0d mismatches %0d", checked, err_total);
	if (err_total == 0 && checked > 0) begin
		$display("Regression OK");
	end else begin
		$display("Regression broken");
	end
	$finish;
endtask

initial begin
	err_total = 0;
	checked = 0;
	cycles = 0;
	resetn_i = 1'b0;
	addr_i = 12'h000;
	wdata_i = 32'h00000000;
	we_i = 1'b0;
	re_i = 1'b0;
	grp_en_task_i = 6'h00;
	grp_dis_task_i = 6'h00;
	// the set and clear alias rows depend on the enable state left by the row above
	rows = '{
		'{12'h500, 32'h0000F0F0, 12'h500, 32'h0000F0F0},
		'{12'h504, 32'h00010001, 12'h504, 32'h0001F0F1},
		'{12'h508, 32'h000000F1, 12'h508, 32'h0001F000},
		'{12'h514, 32'h40000100, 12'h514, 32'h40000100},
		'{12'h5AC, 32'h40000104, 12'h5AC, 32'h40000104},
		'{12'h510, 32'hA5A5A5A4, 12'h510, 32'hA5A5A5A4},
		'{12'h5A8, 32'h0BADF00C, 12'h5A8, 32'h0BADF00C},
		'{12'h800, 32'h000000FF, 12'h800, 32'h000000FF},
		'{12'h814, 32'hFF000000, 12'h814, 32'hFF000000},
		'{12'h5B0, 32'hFFFFFFFF, 12'h5B0, 32'h00000000},
		'{12'h7FC, 32'hFFFFFFFF, 12'h7FC, 32'h00000000}
	};
	repeat (2) @(posedge clk_i);
	resetn_i <= 1'b1;
	// reset values of enable, task end-point and mask words
	rd(12'h500, v);
	chk(v, 32'h00000000);
	rd(12'h5AC, v);
	chk(v, 32'h00000000);
	rd(12'h814, v);
	chk(v, 32'h00000000);
	chk(channel_enable_o, 32'h00000000);
	$display("test reset done");
	// write then read back, strobes back to back
	foreach (rows[i]) begin
		wr(rows[i].wa, rows[i].wd);
		rd(rows[i].ra, v);
		chk(v, rows[i].ex);
	end
	idle();
	chk(rdata_o, 32'h00000000);
	$display("test table done");
	// every group trigger, enable then disable, outsiders untouched
	for (int g = 0; g < NUM_GRP; g++) begin
		m = 32'h00000003 << (5 * g);
		wr(OFF_GROUP_MASK + 12'(4 * g), m);
		wr(OFF_CHAN_ENABLE, 32'h00000000);
		wr(OFF_GRP_EN + 12'(8 * g), 32'h00000000);
		idle();
		chk(channel_enable_o, m);
		wr(OFF_CHAN_ENABLE, 32'hFFFFFFFF);
		wr(OFF_GRP_DIS + 12'(8 * g), 32'h00000000);
		idle();
		chk(channel_enable_o, ~m);
	end
	$display("test groups done");
	// hardware task inputs and same-cycle conflicts: disable wins
	wr(OFF_CHAN_ENABLE, 32'h00000000);
	idle();
	@(posedge clk_i);
	grp_en_task_i <= 6'h04;
	idle();
	chk(channel_enable_o, 32'h00000C00);
	@(posedge clk_i);
	grp_en_task_i <= 6'h05;
	grp_dis_task_i <= 6'h07;
	idle();
	chk(channel_enable_o, 32'h00000000);
	wr(OFF_GRP_EN + 12'h008, 32'h00000000);
	grp_dis_task_i <= 6'h02;
	idle();
	chk(channel_enable_o, 32'h00000000);
	wr(OFF_CHAN_ENABLE_SET, 32'h00000FFF);
	wr(OFF_GRP_DIS, 32'h00000000);
	idle();
	chk(channel_enable_o, 32'h00000FFC);
	$display("test conflicts done");
	// mid-run reset must clear words that now hold non-zero values
	@(posedge clk_i);
	resetn_i <= 1'b0;
	@(posedge clk_i);
	resetn_i <= 1'b1;
	rd(OFF_CHAN_ENABLE, v);
	chk(v, 32'h00000000);
	rd(12'h510, v);
	chk(v, 32'h00000000);
	rd(12'h5AC, v);
	chk(v, 32'h00000000);
	rd(12'h814, v);
	chk(v, 32'h00000000);
	chk(channel_enable_o, 32'h00000000);
	$display("test mid-run reset done");
	print_verdict();
end

endmodule
